/* hw/dmg_defines.svh */
// register offsets, field positions, masks and reset values of the doze and gating block
`ifndef DMG_DEFINES_SVH
`define DMG_DEFINES_SVH

// byte addresses of the register words
`define DMG_OFF_CLK_DIV    8'h00
`define DMG_OFF_GATE1      8'h04
`define DMG_OFF_GATE2      8'h08
`define DMG_OFF_GATE3      8'h0C
`define DMG_OFF_GATE4      8'h10
`define DMG_OFF_FUNC_EN    8'h14
`define DMG_OFF_IDLE_STOP  8'h18
`define DMG_OFF_STATUS     8'h1C

// clock divider register fields
`define DMG_IRQ_FULL_BIT   15
`define DMG_RATIO_MSB      14
`define DMG_RATIO_LSB      12
`define DMG_DOZE_EN_BIT    11

// implemented bits of each register word
`define DMG_CLK_DIV_MASK   32'h0000_F800
`define DMG_GATE1_MASK     32'h0000_38E9
`define DMG_GATE2_MASK     32'h0000_0101
`define DMG_GATE3_MASK     32'h0000_0680
`define DMG_GATE4_MASK     32'h0000_001E
`define DMG_FUNC_EN_MASK   32'h0001_F4FF
`define DMG_IDLE_MASK      32'h0001_FFFF

// reset values
`define DMG_CLK_DIV_RST    32'h0000_0000
`define DMG_GATE_RST       32'h0000_0000
`define DMG_FUNC_EN_RST    32'h0000_0000
`define DMG_IDLE_RST       32'h0000_0000

// number of gated peripheral modules
`define DMG_NMOD           17

`endif

/* hw/dmg_pkg.sv */
// types shared by the doze and module gating block
package dmg_pkg;

  // per-module control bundle driven to one peripheral
  typedef struct packed {
    logic reg_clk_en;  // clock of the module's registers
    logic func_run;    // clock of the module's function
    logic rst;         // module held in reset
    logic wr_block;    // writes to the module's registers ignored
  } dmg_mod_ctl_t;

  // doze settings carried from the register file to the divider
  typedef struct packed {
    logic       enable;
    logic [2:0] ratio;
  } dmg_doze_t;

  // bus slave phase
  typedef enum logic [0:0] {
    DMG_BUS_WAIT,
    DMG_BUS_ANSWER
  } dmg_bus_st_t;

endpackage

/* hw/dmg_doze_div.sv */
// cpu clock enable divider for doze operation
`timescale 1ns/10ps
module dmg_doze_div (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // settings
  input  wire dmg_pkg::dmg_doze_t doze_i,
  // cpu clock enable and the ratio now in force
  output logic                   cpu_tick_o,
  output logic [2:0]             active_ratio_o
);

  logic [6:0] cnt_q;
  logic [6:0] limit;
  logic       wrap;

  // the cpu tick is a one-cycle enable of the peripheral clock, so it never glitches
  assign limit = 7'((8'h01 << active_ratio_o) - 8'h01);
  assign wrap  = (cnt_q == limit);

  // ratio is only taken at a wrap so a period is never cut short; leaving doze is at once
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      active_ratio_o <= 3'h0;
    end else if (!doze_i.enable) begin
      active_ratio_o <= 3'h0;
    end else if (wrap) begin
      active_ratio_o <= doze_i.ratio;
    end
  end

  // period counter running on every peripheral clock edge
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 7'h00;
    end else if (!doze_i.enable || wrap) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= 7'(cnt_q + 7'h01);
    end
  end

  // tick marks the peripheral edge that is also a cpu edge
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cpu_tick_o <= 1'b0;
    end else begin
      cpu_tick_o <= wrap || !doze_i.enable;
    end
  end

  // full speed means a tick on every edge
  full_speed_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (active_ratio_o == 3'h0 && !doze_i.enable) |=> cpu_tick_o)
    else $error("cpu tick missing at full speed");

  // with a ratio above one, ticks never come back to back
  slow_spacing_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cpu_tick_o && doze_i.enable && $stable(doze_i.enable) && active_ratio_o != 3'h0
     && $past(active_ratio_o) != 3'h0) |=> !cpu_tick_o)
    else $error("cpu ticks too close while dozing");

endmodule

/* hw/dmg_gate_cell.sv */
// per-module clock, reset and write gating
`timescale 1ns/10ps
module dmg_gate_cell (
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  // controls for this module
  input  wire logic               gate_i,
  input  wire logic               func_en_i,
  input  wire logic               stop_idle_i,
  input  wire logic               idle_i,
  // gated controls to the module
  output dmg_pkg::dmg_mod_ctl_t   ctl_o
);

  // gate cuts every clock; enable and idle stop only the function
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_o <= '{reg_clk_en: 1'b1, func_run: 1'b0, rst: 1'b1, wr_block: 1'b1};
    end else begin
      ctl_o.reg_clk_en <= !gate_i;
      ctl_o.func_run   <= !gate_i && func_en_i && !(idle_i && stop_idle_i);
      ctl_o.rst        <= gate_i;
      ctl_o.wr_block   <= gate_i;
    end
  end

endmodule

/* hw/dmg_top.sv */
// doze divider, module gating and their apb register file
//
// Notes on behaviour
// - slowdown enable bit 11 starts doze
// - ratio bits 14:12 pick 1:1..1:128, reset 1:1
// - system and peripheral clocks unchanged while dozing
// - cpu clock stays aligned with peripheral clock
// - bit 15 set: interrupt restores full speed
// - bit 15 clear: interrupts leave doze alone
// - gate bit cuts all module clocks
// - gated module ignores writes, reads undefined
// - function enable off keeps registers accessible
// - capture, compare, calendar lack function enable
// - module runs in idle unless stop bit
// - gate1 bits 7,6,5,3,0 gate serial and converter
// - gate2 bit 8 capture, bit 0 compare
// - gate4 bits 4..1 eeprom, refclk, ctmu, detector
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "dmg_defines.svh"
module dmg_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  reset_i,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // system events on the same clock
  input  wire logic                  irq_event_i,
  input  wire logic                  idle_i,
  // clock outputs
  output logic                       cpu_tick_o,
  output logic                       periph_tick_o,
  // per-module controls
  output dmg_pkg::dmg_mod_ctl_t      mod_ctl_o [`DMG_NMOD]
);

  localparam int NMOD = `DMG_NMOD;

  // register words
  logic [31:0]            clk_div_q;
  logic [31:0]            gate1_q;
  logic [31:0]            gate2_q;
  logic [31:0]            gate3_q;
  logic [31:0]            gate4_q;
  logic [31:0]            func_en_q;
  logic [31:0]            idle_stop_q;
  logic [31:0]            status;
  logic [31:0]            rd_data;
  logic                   rd_hit;
  logic                   wr_fire;
  logic [7:0]             addr8;
  logic [NMOD-1:0]        gate_vec;
  logic [2:0]             active_ratio;
  dmg_pkg::dmg_doze_t     doze;
  dmg_pkg::dmg_bus_st_t   bus_st_q;

  assign addr8   = 8'(paddr);
  // a write lands only at the edge where the master sees pready
  assign wr_fire = psel && penable && pwrite && (bus_st_q == dmg_pkg::DMG_BUS_ANSWER) && rd_hit;

  // address decode and read mux; unimplemented bits are masked to zero
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (addr8)
      `DMG_OFF_CLK_DIV:   rd_data = clk_div_q & `DMG_CLK_DIV_MASK;
      `DMG_OFF_GATE1:     rd_data = gate1_q & `DMG_GATE1_MASK;
      `DMG_OFF_GATE2:     rd_data = gate2_q & `DMG_GATE2_MASK;
      `DMG_OFF_GATE3:     rd_data = gate3_q & `DMG_GATE3_MASK;
      `DMG_OFF_GATE4:     rd_data = gate4_q & `DMG_GATE4_MASK;
      `DMG_OFF_FUNC_EN:   rd_data = func_en_q & `DMG_FUNC_EN_MASK;
      `DMG_OFF_IDLE_STOP: rd_data = idle_stop_q & `DMG_IDLE_MASK;
      `DMG_OFF_STATUS:    rd_data = status;
      default:            rd_hit  = 1'b0;
    endcase
  end

  // status shows what the divider is really doing, which lags a ratio write
  assign status = {28'h000_0000, (active_ratio != 3'h0), active_ratio};

  // bus phase: one wait cycle in the access phase, then the answer
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_st_q <= dmg_pkg::DMG_BUS_WAIT;
    end else begin
      case (bus_st_q)
        dmg_pkg::DMG_BUS_WAIT: begin
          if (psel && penable) begin
            bus_st_q <= dmg_pkg::DMG_BUS_ANSWER;
          end
        end
        dmg_pkg::DMG_BUS_ANSWER: begin
          bus_st_q <= dmg_pkg::DMG_BUS_WAIT;
        end
        default: begin
          bus_st_q <= dmg_pkg::DMG_BUS_WAIT;
        end
      endcase
    end
  end

  // answer signals, all registered
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && bus_st_q == dmg_pkg::DMG_BUS_WAIT) begin
      pready  <= 1'b1;
      pslverr <= !rd_hit;
      prdata  <= pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // clock divider register; a software write in the same cycle beats the interrupt clear
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      clk_div_q <= `DMG_CLK_DIV_RST;
    end else if (wr_fire && addr8 == `DMG_OFF_CLK_DIV) begin
      clk_div_q <= pwdata & `DMG_CLK_DIV_MASK;
    end else if (irq_event_i && clk_div_q[`DMG_IRQ_FULL_BIT]) begin
      clk_div_q[`DMG_DOZE_EN_BIT] <= 1'b0;
    end
  end

  // gate registers; held at zero from reset so every module starts clocked
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      gate1_q <= `DMG_GATE_RST;
      gate2_q <= `DMG_GATE_RST;
      gate3_q <= `DMG_GATE_RST;
      gate4_q <= `DMG_GATE_RST;
    end else if (wr_fire) begin
      if (addr8 == `DMG_OFF_GATE1) begin
        gate1_q <= pwdata & `DMG_GATE1_MASK;
      end
      if (addr8 == `DMG_OFF_GATE2) begin
        gate2_q <= pwdata & `DMG_GATE2_MASK;
      end
      if (addr8 == `DMG_OFF_GATE3) begin
        gate3_q <= pwdata & `DMG_GATE3_MASK;
      end
      if (addr8 == `DMG_OFF_GATE4) begin
        gate4_q <= pwdata & `DMG_GATE4_MASK;
      end
    end
  end

  // function enable and idle stop words; absent enables are masked off
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      func_en_q   <= `DMG_FUNC_EN_RST;
      idle_stop_q <= `DMG_IDLE_RST;
    end else if (wr_fire) begin
      if (addr8 == `DMG_OFF_FUNC_EN) begin
        func_en_q <= pwdata & `DMG_FUNC_EN_MASK;
      end
      if (addr8 == `DMG_OFF_IDLE_STOP) begin
        idle_stop_q <= pwdata & `DMG_IDLE_MASK;
      end
    end
  end

  // gate bit of each module, index order matches the module numbering
  assign gate_vec = {
    gate4_q[1], gate4_q[2], gate4_q[3], gate4_q[4],
    gate3_q[7], gate3_q[9], gate3_q[10],
    gate2_q[0], gate2_q[8],
    gate1_q[0], gate1_q[3], gate1_q[6], gate1_q[5], gate1_q[7],
    gate1_q[13], gate1_q[12], gate1_q[11]
  };

  // doze settings to the divider
  assign doze.enable = clk_div_q[`DMG_DOZE_EN_BIT];
  assign doze.ratio  = clk_div_q[`DMG_RATIO_MSB:`DMG_RATIO_LSB];

  dmg_doze_div u_div (
    .mclk_i         (mclk_i),
    .reset_i        (reset_i),
    .doze_i         (doze),
    .cpu_tick_o     (cpu_tick_o),
    .active_ratio_o (active_ratio)
  );

  // peripheral clock enable never slows, doze or not
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      periph_tick_o <= 1'b0;
    end else begin
      periph_tick_o <= 1'b1;
    end
  end

  // one gate cell per module; modules with no enable run whenever ungated and not stopped in idle
  for (genvar m = 0; m < NMOD; m++) begin : g_mod
    localparam logic HAS_EN = 1'((`DMG_FUNC_EN_MASK >> m) & 32'h0000_0001);
    dmg_gate_cell u_cell (
      .mclk_i      (mclk_i),
      .reset_i     (reset_i),
      .gate_i      (gate_vec[m]),
      .func_en_i   (HAS_EN ? func_en_q[m] : 1'b1),
      .stop_idle_i (idle_stop_q[m]),
      .idle_i      (idle_i),
      .ctl_o       (mod_ctl_o[m])
    );
  end

  // the answer comes exactly one cycle after the access phase opens
  answer_delay_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (psel && penable && !pready && !$past(penable)) |=> pready)
    else $error("apb answer not one cycle after access start");

  // unmapped addresses answer with an error
  unmapped_err_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (psel && penable && !pready && !rd_hit) |=> (pready && pslverr))
    else $error("unmapped address without slave error");

  // reserved bits of the gate1, gate3 and function enable words stay zero
  reserved_zero_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    ((gate1_q & ~`DMG_GATE1_MASK) == 32'h0000_0000) &&
    ((gate3_q & ~`DMG_GATE3_MASK) == 32'h0000_0000) &&
    ((func_en_q & ~`DMG_FUNC_EN_MASK) == 32'h0000_0000))
    else $error("reserved register bits set");

  // interrupt with return bit set drops doze one edge later
  irq_restore_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (irq_event_i && clk_div_q[`DMG_IRQ_FULL_BIT] && !wr_fire) |=> !clk_div_q[`DMG_DOZE_EN_BIT])
    else $error("interrupt did not restore full speed");

  // interrupt with return bit clear leaves doze settings unchanged
  irq_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (irq_event_i && !clk_div_q[`DMG_IRQ_FULL_BIT] && !wr_fire) |=> $stable(clk_div_q))
    else $error("interrupt changed doze settings");

  // a written clock divider word lands on the answer edge
  div_write_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (wr_fire && addr8 == `DMG_OFF_CLK_DIV)
      |=> (clk_div_q == ($past(pwdata) & `DMG_CLK_DIV_MASK)))
    else $error("clock divider write lost");

  // a set timer gate holds that timer in reset two edges on
  timer_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (gate1_q[11] && $past(gate1_q[11])) |-> (mod_ctl_o[0].rst && !mod_ctl_o[0].reg_clk_en))
    else $error("gated timer not in reset");

  // capture gate blocks writes and stops the function
  capture_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (gate2_q[8] && $past(gate2_q[8])) |-> (mod_ctl_o[8].wr_block && !mod_ctl_o[8].func_run))
    else $error("gated capture still writable");

  // idle with the stop bit set halts the function but keeps register clock
  idle_stop_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (idle_i && idle_stop_q[4] && !gate_vec[4]) |=> (!mod_ctl_o[4].func_run
      && mod_ctl_o[4].reg_clk_en))
    else $error("idle stop not applied");

  // compare has no enable so ungated and not idle it runs
  no_enable_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!gate_vec[9] && !idle_i) |=> mod_ctl_o[9].func_run)
    else $error("compare module not running while ungated");

  // enable off stops the function yet leaves registers reachable
  func_off_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!func_en_q[6] && !gate_vec[6]) |=> (!mod_ctl_o[6].func_run && !mod_ctl_o[6].wr_block))
    else $error("disabled function blocked its registers");

  // a cpu tick is always on a peripheral tick
  tick_aligned_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    cpu_tick_o |-> periph_tick_o)
    else $error("cpu tick off the peripheral grid");

  // the peripheral tick never drops once running
  periph_steady_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    periph_tick_o |=> periph_tick_o)
    else $error("peripheral tick dropped");

  // setting the slowdown bit by software turns doze on
  doze_enter_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (wr_fire && addr8 == `DMG_OFF_CLK_DIV && pwdata[`DMG_DOZE_EN_BIT]) |=> doze.enable)
    else $error("slowdown write did not enable doze");

  // with doze off the divider drops back to full speed at once
  ratio_off_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    !doze.enable |=> (active_ratio == 3'h0))
    else $error("ratio still in force while doze off");

  // the ratio in force only switches on a cpu edge, so no period is cut short
  ratio_switch_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $changed(active_ratio) |-> cpu_tick_o)
    else $error("ratio switched inside a cpu period");

  // an interrupt with the return bit clear keeps doze running
  irq_doze_kept_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (irq_event_i && !clk_div_q[`DMG_IRQ_FULL_BIT] && doze.enable && !wr_fire) |=> doze.enable)
    else $error("interrupt left doze without return bit");

  // a gated two-wire module refuses writes
  two_wire_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (gate1_q[7] && $past(gate1_q[7])) |-> mod_ctl_o[3].wr_block)
    else $error("gated two-wire module still writable");

  // a gated converter is held in reset
  converter_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (gate1_q[0] && $past(gate1_q[0])) |-> mod_ctl_o[7].rst)
    else $error("gated converter not in reset");

  // a gated compare module refuses writes
  compare_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (gate2_q[0] && $past(gate2_q[0])) |-> mod_ctl_o[9].wr_block)
    else $error("gated compare module still writable");

  // a gated calendar stops and sits in reset
  calendar_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (gate3_q[9] && $past(gate3_q[9])) |-> (mod_ctl_o[11].rst && !mod_ctl_o[11].func_run))
    else $error("gated calendar still running");

  // a gated voltage detector sits in reset
  detector_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (gate4_q[1] && $past(gate4_q[1])) |-> mod_ctl_o[16].rst)
    else $error("gated voltage detector not in reset");

  // a gate cuts both clocks of the eeprom
  eeprom_clock_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    gate_vec[13] |=> (!mod_ctl_o[13].reg_clk_en && !mod_ctl_o[13].func_run))
    else $error("gated eeprom still clocked");

  // idle without the stop bit keeps an enabled module running
  idle_run_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (idle_i && !idle_stop_q[1] && func_en_q[1] && !gate_vec[1]) |=> mod_ctl_o[1].func_run)
    else $error("module stopped in idle without stop bit");

endmodule

/* test/dmg_top_tb_top.sv */
// self-checking bench of the doze divider and module gating block
`timescale 1ns/10ps
`include "dmg_defines.svh"
module dmg_top_tb_top;
  logic                  mclk_i;
  logic                  reset_i;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  irq_event_i;
  logic                  idle_i;
  logic                  cpu_tick_o;
  logic                  periph_tick_o;
  dmg_pkg::dmg_mod_ctl_t mod_ctl [`DMG_NMOD];
  int                    err_total;
  int                    num_checks;
  logic [31:0]           rd;
  logic                  er;
  int                    g;
  // gate register and bit of each module, in mod_ctl index order
  localparam logic [7:0] GOFF [17] = '{`DMG_OFF_GATE1, `DMG_OFF_GATE1, `DMG_OFF_GATE1,
    `DMG_OFF_GATE1, `DMG_OFF_GATE1, `DMG_OFF_GATE1, `DMG_OFF_GATE1, `DMG_OFF_GATE1,
    `DMG_OFF_GATE2, `DMG_OFF_GATE2, `DMG_OFF_GATE3, `DMG_OFF_GATE3, `DMG_OFF_GATE3,
    `DMG_OFF_GATE4, `DMG_OFF_GATE4, `DMG_OFF_GATE4, `DMG_OFF_GATE4};
  localparam int GBIT [17] = '{11, 12, 13, 7, 5, 6, 3, 0, 8, 0, 10, 9, 7, 4, 3, 2, 1};
  // modules without a function enable run as soon as they are ungated
  localparam logic [16:0] NO_EN = 17'h0_0B00;

  dmg_top #(.ADDR_W(8)) i_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_event_i(irq_event_i),
    .idle_i(idle_i), .cpu_tick_o(cpu_tick_o), .periph_tick_o(periph_tick_o),
    .mod_ctl_o(mod_ctl));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // one apb transfer; the answer is taken at the rising edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // cycles between two cpu ticks, bounded so a stuck divider cannot hang
  task automatic gap_of(output int gp);
    int n;
    n = 0;
    while (cpu_tick_o !== 1'b1 && n < 300) begin
      @(negedge mclk_i);
      n++;
    end
    @(negedge mclk_i);
    gp = 1;
    while (cpu_tick_o !== 1'b1 && gp < 300) begin
      @(negedge mclk_i);
      gp++;
    end
  endtask

  task automatic t_reset_regs();
    logic [31:0] msk [7];
    msk = '{`DMG_CLK_DIV_MASK, `DMG_GATE1_MASK, `DMG_GATE2_MASK, `DMG_GATE3_MASK,
      `DMG_GATE4_MASK, `DMG_FUNC_EN_MASK, `DMG_IDLE_MASK};
    for (int k = 0; k < `DMG_NMOD; k++) begin
      chk("rst", mod_ctl[k].rst, 1'b0);
      chk("run", mod_ctl[k].func_run, NO_EN[k]);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset read", rd, 32'h0);
    end
    // all ones shows which bits exist; unimplemented ones must stay zero
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, 8'(4 * i), 32'hFFFF_FFFF);
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("mask", rd, msk[i]);
      apb(1'b1, 8'(4 * i), 32'h0);
    end
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    chk("unmapped err", er, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped rd err", er, 1'b1);
    $display("test reset_regs done");
  endtask

  task automatic t_gates();
    for (int m = 0; m < `DMG_NMOD; m++) begin
      apb(1'b1, GOFF[m], 32'h1 << GBIT[m]);
      cyc(3);
      for (int k = 0; k < `DMG_NMOD; k++) begin
        chk("rst", mod_ctl[k].rst, k == m);
        chk("wr_block", mod_ctl[k].wr_block, k == m);
        chk("reg_clk", mod_ctl[k].reg_clk_en, k != m);
        chk("run", mod_ctl[k].func_run, (k != m) && NO_EN[k]);
      end
      apb(1'b1, GOFF[m], 32'h0);
    end
    $display("test gates done");
  endtask

  task automatic t_enable_idle();
    apb(1'b1, `DMG_OFF_FUNC_EN, `DMG_FUNC_EN_MASK);
    apb(1'b1, `DMG_OFF_GATE1, 32'h0000_0800);
    cyc(3);
    chk("run gated", mod_ctl[0].func_run, 1'b0);
    apb(1'b1, `DMG_OFF_GATE1, 32'h0);
    cyc(3);
    for (int k = 0; k < `DMG_NMOD; k++)
      chk("run en", mod_ctl[k].func_run, 1'b1);
    apb(1'b1, `DMG_OFF_FUNC_EN, 32'h0);
    cyc(3);
    chk("run off", mod_ctl[4].func_run, 1'b0);
    chk("regs live", mod_ctl[4].reg_clk_en, 1'b1);
    apb(1'b1, `DMG_OFF_FUNC_EN, `DMG_FUNC_EN_MASK);
    apb(1'b1, `DMG_OFF_IDLE_STOP, 32'h0000_0011);
    @(posedge mclk_i);
    idle_i <= 1'b1;
    cyc(3);
    chk("idle stop", mod_ctl[0].func_run, 1'b0);
    chk("idle run", mod_ctl[1].func_run, 1'b1);
    chk("idle stop uart", mod_ctl[4].func_run, 1'b0);
    chk("idle regs", mod_ctl[4].reg_clk_en, 1'b1);
    @(posedge mclk_i);
    idle_i <= 1'b0;
    apb(1'b1, `DMG_OFF_IDLE_STOP, 32'h0);
    apb(1'b1, `DMG_OFF_FUNC_EN, 32'h0);
    $display("test enable_idle done");
  endtask

  task automatic t_doze();
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, `DMG_OFF_CLK_DIV, 32'h0000_0800 | (32'(r) << `DMG_RATIO_LSB));
      cyc(130);
      gap_of(g);
      chk("tick gap", 32'(g), 32'h1 << r);
      chk("periph", periph_tick_o, 1'b1);
      apb(1'b0, `DMG_OFF_STATUS, 32'h0);
      chk("status", rd, ((r != 0) ? 32'h8 : 32'h0) | 32'(r));
    end
    apb(1'b1, `DMG_OFF_CLK_DIV, 32'h0);
    cyc(2);
    gap_of(g);
    chk("tick off", 32'(g), 32'h1);
    $display("test doze done");
  endtask

  task automatic irq_pulse();
    @(posedge mclk_i);
    irq_event_i <= 1'b1;
    @(posedge mclk_i);
    irq_event_i <= 1'b0;
    cyc(3);
  endtask

  task automatic t_interrupt();
    apb(1'b1, `DMG_OFF_CLK_DIV, 32'h0000_B800);
    cyc(130);
    irq_pulse();
    apb(1'b0, `DMG_OFF_CLK_DIV, 32'h0);
    chk("irq return div", rd, 32'h0000_B000);
    gap_of(g);
    chk("irq return gap", 32'(g), 32'h1);
    apb(1'b1, `DMG_OFF_CLK_DIV, 32'h0000_3800);
    cyc(130);
    irq_pulse();
    apb(1'b0, `DMG_OFF_CLK_DIV, 32'h0);
    chk("irq kept div", rd, 32'h0000_3800);
    gap_of(g);
    chk("irq kept gap", 32'(g), 32'h8);
    apb(1'b1, `DMG_OFF_CLK_DIV, 32'h0);
    $display("test interrupt done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog: the tests need about 2200 cycles
  initial begin
    repeat (60000) @(posedge mclk_i);
    err_total++;
    summarize();
  end

  initial begin
    err_total = 0;
    num_checks = 0;
    reset_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    irq_event_i = 1'b0;
    idle_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    cyc(2);
    t_reset_regs();
    t_gates();
    t_enable_idle();
    t_doze();
    t_interrupt();
    summarize();
  end
endmodule
